// [rtl/ebcr_pkg.sv]
/*
 * Shared constants and types for the external bus cycle engine.
 * Assumes a system clock domain for requests and a bus link clock for the pins.
 */
// Notes on behaviour
// - Every external cycle runs the phases address, delay, write setup, access and hold in that order.
// - Phase lengths are address 1, 2 or 5, delay 0..3, write setup 0..1, access 1..32 and hold 0..3 bus clocks.
// - With ready enabled the peripheral stretches the access phase until ready is seen active.
// - The active level of the ready input is selectable, high or low.
// - Synchronous ready is sampled without an extra stage and must be driven in step with the reference clock.
// - Asynchronous ready passes an extra synchroniser, so every ready cycle has at least one wait state.
// - Ready sampled inactive adds one wait state; ready sampled active ends the access phase.
// - Ready is looked at only after the programmed access phase length has elapsed.
// - Read data is captured on the edge that raises the read strobe; the address moves on that edge only when no hold phase follows.
// - Shared mode puts the address on the 16 shared lines with a latch strobe, separate mode uses 24 address lines.
// - Each cycle drives chip select, high byte enable, read strobe and low and high write strobes.
// - Signal transitions on the bus stay at least 12.5 ns apart.
// - The reference clock output is the bus clock with the fast driver selected.
package ebcr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int AD_W = 16;
  localparam int LEN_W = 6;

  // Phase lengths in bus clocks
  localparam logic [2:0] AB_LEN_SHORT = 3'h1;
  localparam logic [2:0] AB_LEN_LONG = 3'h2;
  localparam logic [2:0] AB_LEN_SPECIAL = 3'h5;

  // Minimum spacing of pin transitions, and the link period
  localparam int MIN_TRANS_PS = 12500;
  localparam int LINK_PERIOD_PS = 80000;
  localparam int MIN_PHASE_CYC = (MIN_TRANS_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;

  // Reset values
  localparam logic [15:0] RDATA_RST = 16'h0000;
  localparam logic [23:0] ADDR_RST = 24'h0000_00;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [2:0] address_phase_length;
    logic [1:0] delay_phase_length;
    logic write_data_setup_phase_length;
    logic [4:0] access_phase_length;   // Stored as length minus one
    logic [1:0] hold_phase_length;
    logic ready_en;
    logic ready_active_high;
    logic ready_async;
    logic shared_bus_mode;
  } ebcr_cfg_type;

  typedef struct packed {
    logic write;
    logic [1:0] byte_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ebcr_req_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_AB,
    ST_C,
    ST_D,
    ST_E,
    ST_RDY,
    ST_F
  } ebcr_state_type;

endpackage

// [rtl/ebcr_core.sv]
/*
 * External bus cycle engine: takes one request at a time in the system domain and
 * runs a phased read or write cycle on the bus pins in the link clock domain.
 * Assumes the link clock is the bus clock, also driven out as the reference clock.
 */
`timescale 1ns/1ps
module ebcr_core (
  // System side
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_CE,
  // Link clock
  input wire logic I_LINK_CLK,
  // Request
  input wire logic I_REQ_VALID,
  input wire ebcr_pkg::ebcr_req_type I_REQ,
  input wire ebcr_pkg::ebcr_cfg_type I_CFG,
  output logic O_REQ_READY,
  output logic O_DONE,
  output logic [ebcr_pkg::DATA_W-1:0] O_RDATA,
  output logic O_REF_CLK_FAST,
  // Bus pins
  input wire logic I_READY,
  input wire logic [ebcr_pkg::AD_W-1:0] I_AD,
  input wire logic [ebcr_pkg::DATA_W-1:0] I_D,
  output logic O_CS_N,
  output logic O_ALE,
  output logic O_RD_N,
  output logic O_WRL_N,
  output logic O_WRH_N,
  output logic O_BHE_N,
  output logic [ebcr_pkg::ADDR_W-1:0] O_ADDR,
  output logic [ebcr_pkg::AD_W-1:0] O_AD,
  output logic O_AD_OE,
  output logic [ebcr_pkg::DATA_W-1:0] O_D,
  output logic O_D_OE
);

  ////////////////////////////////////////////////////////////////////////////
  // System domain: request hold and handshake
  logic busy;
  logic go_tgl;
  logic done_s1, done_s2, done_s3;
  ebcr_pkg::ebcr_req_type req_hold;
  ebcr_pkg::ebcr_cfg_type cfg_hold;
  logic done_tgl;
  logic [ebcr_pkg::DATA_W-1:0] rdata_link;

  wire accept = I_CE && I_REQ_VALID && !busy;
  wire done_edge = I_CE && (done_s2 ^ done_s3);

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      busy <= 1'b0;
      go_tgl <= 1'b0;
      req_hold <= '0;
      cfg_hold <= '0;
    end else if (accept) begin
      busy <= 1'b1;
      go_tgl <= ~go_tgl;
      req_hold <= I_REQ;
      cfg_hold <= I_CFG;
    end else if (done_edge) begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
      O_REQ_READY <= 1'b0;
      O_DONE <= 1'b0;
      O_RDATA <= ebcr_pkg::RDATA_RST;
      O_REF_CLK_FAST <= 1'b0;
    end else if (I_CE) begin
      done_s1 <= done_tgl;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
      O_REQ_READY <= !(accept || (busy && !done_edge));
      O_DONE <= done_edge;
      O_REF_CLK_FAST <= 1'b1;
      if (done_edge) begin
        // Link holds its read data stable until the next request
        O_RDATA <= rdata_link;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: crossings
  logic ce_s1, ce_s2;
  logic go_s1, go_s2, go_s3;
  logic rdy_q;
  logic rdy_s1, rdy_s2;

  always_ff @(posedge I_LINK_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ce_s1 <= 1'b0;
      ce_s2 <= 1'b0;
    end else begin
      ce_s1 <= I_CE;
      ce_s2 <= ce_s1;
    end
  end

  wire ce_l = ce_s2;

  always_ff @(posedge I_LINK_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      go_s1 <= 1'b0;
      go_s2 <= 1'b0;
      go_s3 <= 1'b0;
      rdy_q <= 1'b0;
      rdy_s1 <= 1'b0;
      rdy_s2 <= 1'b0;
    end else if (ce_l) begin
      go_s1 <= go_tgl;
      go_s2 <= go_s1;
      go_s3 <= go_s2;
      rdy_q <= I_READY;
      rdy_s1 <= I_READY;
      rdy_s2 <= rdy_s1;
    end
  end

  wire go = go_s2 ^ go_s3;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: phase lengths and sequencing
  ebcr_pkg::ebcr_state_type st, next_st;
  logic [ebcr_pkg::LEN_W-1:0] cnt, next_cnt;

  wire [ebcr_pkg::LEN_W-1:0] ab_len = (cfg_hold.address_phase_length == ebcr_pkg::AB_LEN_SPECIAL) ? 6'h05 :
    (cfg_hold.address_phase_length == ebcr_pkg::AB_LEN_LONG) ? 6'h02 : 6'h01;
  wire [ebcr_pkg::LEN_W-1:0] c_len = {4'h0, cfg_hold.delay_phase_length};
  wire [ebcr_pkg::LEN_W-1:0] d_len = {5'h00, cfg_hold.write_data_setup_phase_length};
  wire [ebcr_pkg::LEN_W-1:0] e_raw = {1'b0, cfg_hold.access_phase_length} + 6'h01;
  // Slow enough link clock keeps pin edges apart without extra waits
  wire [ebcr_pkg::LEN_W-1:0] e_min = ebcr_pkg::LEN_W'(ebcr_pkg::MIN_PHASE_CYC);
  wire [ebcr_pkg::LEN_W-1:0] e_len = (e_raw < e_min) ? e_min : e_raw;
  wire [ebcr_pkg::LEN_W-1:0] f_len = {4'h0, cfg_hold.hold_phase_length};

  // Ready polarity and sampling point
  wire rdy_sample = cfg_hold.ready_async ? rdy_s2 : rdy_q;
  wire rdy_ok = (rdy_sample == cfg_hold.ready_active_high);
  wire phase_end = (cnt == 6'h01);
  wire is_read = !req_hold.write;

  // Zero-length phases are skipped when moving on
  wire ebcr_pkg::ebcr_state_type after_e = (f_len != 6'h00) ? ebcr_pkg::ST_F : ebcr_pkg::ST_IDLE;
  wire ebcr_pkg::ebcr_state_type after_c = (d_len != 6'h00) ? ebcr_pkg::ST_D : ebcr_pkg::ST_E;
  wire ebcr_pkg::ebcr_state_type after_ab = (c_len != 6'h00) ? ebcr_pkg::ST_C : after_c;

  function automatic logic [ebcr_pkg::LEN_W-1:0] len_of(input ebcr_pkg::ebcr_state_type s,
      input logic [ebcr_pkg::LEN_W-1:0] l_ab, input logic [ebcr_pkg::LEN_W-1:0] l_c,
      input logic [ebcr_pkg::LEN_W-1:0] l_d, input logic [ebcr_pkg::LEN_W-1:0] l_e,
      input logic [ebcr_pkg::LEN_W-1:0] l_f);
    case (s)
      ebcr_pkg::ST_AB: len_of = l_ab;
      ebcr_pkg::ST_C: len_of = l_c;
      ebcr_pkg::ST_D: len_of = l_d;
      ebcr_pkg::ST_E: len_of = l_e;
      ebcr_pkg::ST_F: len_of = l_f;
      default: len_of = 6'h01;
    endcase
  endfunction

  always_comb begin
    next_st = st;
    case (st)
      ebcr_pkg::ST_IDLE: begin
        if (go) begin
          next_st = ebcr_pkg::ST_AB;
        end
      end
      ebcr_pkg::ST_AB: begin
        if (phase_end) begin
          next_st = after_ab;
        end
      end
      ebcr_pkg::ST_C: begin
        if (phase_end) begin
          next_st = after_c;
        end
      end
      ebcr_pkg::ST_D: begin
        if (phase_end) begin
          next_st = ebcr_pkg::ST_E;
        end
      end
      ebcr_pkg::ST_E: begin
        // Ready is only looked at once the programmed access length is spent
        if (phase_end) begin
          if (!cfg_hold.ready_en) begin
            next_st = after_e;
          end else if (!cfg_hold.ready_async && rdy_ok) begin
            next_st = after_e;
          end else begin
            next_st = ebcr_pkg::ST_RDY;
          end
        end
      end
      ebcr_pkg::ST_RDY: begin
        if (rdy_ok) begin
          next_st = after_e;
        end
      end
      ebcr_pkg::ST_F: begin
        if (phase_end) begin
          next_st = ebcr_pkg::ST_IDLE;
        end
      end
      default: next_st = ebcr_pkg::ST_IDLE;
    endcase
  end

  assign next_cnt = (next_st != st) ? len_of(next_st, ab_len, c_len, d_len, e_len, f_len) :
    (cnt > 6'h01) ? cnt - 6'h01 : cnt;

  wire finish = (st != ebcr_pkg::ST_IDLE) && (next_st == ebcr_pkg::ST_IDLE);
  wire strobe_end = ((st == ebcr_pkg::ST_E) || (st == ebcr_pkg::ST_RDY)) &&
    (next_st != ebcr_pkg::ST_E) && (next_st != ebcr_pkg::ST_RDY);

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: next pin values
  wire active = (next_st != ebcr_pkg::ST_IDLE);
  wire in_access = (next_st == ebcr_pkg::ST_E) || (next_st == ebcr_pkg::ST_RDY);
  wire in_addr = (next_st == ebcr_pkg::ST_AB);
  wire data_phase = (next_st == ebcr_pkg::ST_D) || in_access || (next_st == ebcr_pkg::ST_F);
  wire shared = cfg_hold.shared_bus_mode;

  wire next_ale = shared && in_addr;
  wire next_rd_n = !(in_access && is_read);
  wire next_wrl_n = !(in_access && req_hold.write && req_hold.byte_en[0]);
  wire next_wrh_n = !(in_access && req_hold.write && req_hold.byte_en[1]);
  wire next_bhe_n = !(active && req_hold.byte_en[1]);
  wire [ebcr_pkg::ADDR_W-1:0] next_addr = active ? req_hold.addr : ebcr_pkg::ADDR_RST;
  wire next_ad_oe = shared && active && (in_addr || (req_hold.write && data_phase));
  wire [ebcr_pkg::AD_W-1:0] next_ad = in_addr ? req_hold.addr[ebcr_pkg::AD_W-1:0] : req_hold.wdata;
  wire next_d_oe = !shared && req_hold.write && data_phase;

  always_ff @(posedge I_LINK_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      st <= ebcr_pkg::ST_IDLE;
      cnt <= 6'h00;
      done_tgl <= 1'b0;
      rdata_link <= ebcr_pkg::RDATA_RST;
    end else if (ce_l) begin
      st <= next_st;
      cnt <= next_cnt;
      if (finish) begin
        done_tgl <= ~done_tgl;
      end
      // Same edge that raises the read strobe
      if (strobe_end && is_read) begin
        rdata_link <= shared ? I_AD : I_D;
      end
    end
  end

  always_ff @(posedge I_LINK_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_CS_N <= 1'b1;
      O_ALE <= 1'b0;
      O_RD_N <= 1'b1;
      O_WRL_N <= 1'b1;
      O_WRH_N <= 1'b1;
      O_BHE_N <= 1'b1;
      O_ADDR <= ebcr_pkg::ADDR_RST;
      O_AD <= 16'h0000;
      O_AD_OE <= 1'b0;
      O_D <= 16'h0000;
      O_D_OE <= 1'b0;
    end else if (ce_l) begin
      O_CS_N <= !active;
      O_ALE <= next_ale;
      O_RD_N <= next_rd_n;
      O_WRL_N <= next_wrl_n;
      O_WRH_N <= next_wrh_n;
      O_BHE_N <= next_bhe_n;
      O_ADDR <= next_addr;
      O_AD <= next_ad;
      O_AD_OE <= next_ad_oe;
      O_D <= req_hold.wdata;
      O_D_OE <= next_d_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_phase_order: assert property (@(posedge I_LINK_CLK) disable iff (!I_NRST)
    (ce_l && st == ebcr_pkg::ST_C) |=> (st inside {ebcr_pkg::ST_C, ebcr_pkg::ST_D, ebcr_pkg::ST_E}))
    else $error("delay phase left to a wrong phase");

  a_access_length: assert property (@(posedge I_LINK_CLK) disable iff (!I_NRST)
    (ce_l && st != ebcr_pkg::ST_E && next_st == ebcr_pkg::ST_E) |=> (cnt == e_len))
    else $error("access phase loaded with wrong length");

  a_ready_extends: assert property (@(posedge I_LINK_CLK) disable iff (!I_NRST)
    (ce_l && st == ebcr_pkg::ST_RDY && !rdy_ok) |=> (st == ebcr_pkg::ST_RDY && !O_CS_N))
    else $error("cycle ended without ready");

  a_async_wait: assert property (@(posedge I_LINK_CLK) disable iff (!I_NRST)
    (ce_l && st == ebcr_pkg::ST_E && phase_end && cfg_hold.ready_en && cfg_hold.ready_async)
    |=> (st == ebcr_pkg::ST_RDY))
    else $error("asynchronous ready cycle without wait state");

  a_ready_polarity: assert property (@(posedge I_LINK_CLK) disable iff (!I_NRST)
    (ce_l && st == ebcr_pkg::ST_RDY && rdy_sample == cfg_hold.ready_active_high)
    |=> (st != ebcr_pkg::ST_RDY))
    else $error("ready of selected level not honoured");

  a_strobe_access: assert property (@(posedge I_LINK_CLK) disable iff (!I_NRST)
    (!O_RD_N || !O_WRL_N || !O_WRH_N) |-> (st inside {ebcr_pkg::ST_E, ebcr_pkg::ST_RDY}) && !O_CS_N)
    else $error("strobe outside access phase");

  a_latch_shared: assert property (@(posedge I_LINK_CLK) disable iff (!I_NRST)
    O_ALE |-> (cfg_hold.shared_bus_mode && st == ebcr_pkg::ST_AB && O_AD_OE && O_AD == O_ADDR[15:0]))
    else $error("address latch strobe without address on shared lines");

  a_read_capture: assert property (@(posedge I_LINK_CLK) disable iff (!I_NRST)
    (ce_l && strobe_end && is_read) |=> (O_RD_N && $past(O_RD_N) == 1'b0))
    else $error("read data not captured at strobe rise");

  a_request_taken: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (accept) |=> (busy && !O_REQ_READY))
    else $error("accepted request left ready high");

  c_read_cycle: cover property (@(posedge I_LINK_CLK) disable iff (!I_NRST)
    (ce_l && strobe_end && is_read));
  c_ready_wait: cover property (@(posedge I_LINK_CLK) disable iff (!I_NRST)
    (st == ebcr_pkg::ST_RDY) ##1 (st == ebcr_pkg::ST_RDY) ##1 (st == ebcr_pkg::ST_F));
  c_shared_write: cover property (@(posedge I_LINK_CLK) disable iff (!I_NRST)
    (O_ALE && req_hold.write));

endmodule

// [sim/ebcr_mem_model.sv]
/*
 * Behavioural memory on the far side of the external bus, 256 words deep.
 * Assumes pins are registered on the bus clock and read data is taken at the rising read strobe.
 */
`timescale 1ns/1ps
module ebcr_mem_model (
  // Bus clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Behaviour settings
  input wire logic ready_high,
  input wire logic shared,
  input wire logic [3:0] wait_cyc,
  // Device pins
  input wire logic cs_n,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wrl_n,
  input wire logic wrh_n,
  input wire logic [23:0] addr,
  input wire logic [15:0] ad_out,
  input wire logic ad_oe,
  input wire logic [15:0] d_out,
  // Driven back
  output logic ready,
  output logic [15:0] rd_drive
);
  logic [15:0] mem [0:255];
  logic [7:0] idx;
  logic [3:0] cnt;
  logic act;
  logic [15:0] last;
  wire strobe = !rd_n || !wrl_n || !wrh_n;
  wire [15:0] wval = ad_oe ? ad_out : d_out;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 4'h0;
      act <= 1'b0;
      last <= 16'h0000;
      idx <= 8'h00;
    end else begin
      if (ale) begin
        idx <= ad_out[7:0];
      end else if (!shared && !cs_n) begin
        idx <= addr[7:0];
      end
      cnt <= !strobe ? 4'h0 : (cnt == 4'hf ? cnt : cnt + 4'h1);
      // Registered on the bus clock, released once the strobe rises
      act <= strobe && (cnt >= wait_cyc);
      if (!rd_n) last <= mem[idx];
      if (!wrl_n) mem[idx][7:0] <= wval[7:0];
      if (!wrh_n) mem[idx][15:8] <= wval[15:8];
    end
  end
  assign ready = ready_high ? act : !act;
  // Released lines show the inverse of the last word, never a stale match
  assign rd_drive = !rd_n ? mem[idx] : ~last;
endmodule

// [sim/external_bus_cycle_ready_bench.sv]
/*
 * Self-checking bench for the external bus cycle engine with a memory model on the pins.
 * Assumes the link clock is unrelated to the system clock and the model sits on the bus.
 */
`timescale 1ns/1ps
module external_bus_cycle_ready_bench;
  logic clk = 1'b0, link_clk = 1'b0, nrst = 1'b0, ce = 1'b1, req_valid = 1'b0;
  ebcr_pkg::ebcr_req_type req = '0;
  ebcr_pkg::ebcr_cfg_type cfg = '0;
  logic [3:0] wait_cyc = 4'h0;
  logic req_ready, done, ref_fast, ready, cs_n, ale, rd_n, wrl_n, wrh_n, bhe_n, ad_oe, d_oe;
  logic [15:0] rdata, ad_out, d_out, rd_drive, ad_in;
  logic [23:0] addr;
  logic [1:0] be_cur = 2'b11;
  logic [15:0] shadow [0:255];
  int bad_count = 0, samples_checked = 0, cs_cnt, ale_cnt, str_cnt, lane_bad;
  assign ad_in = ad_oe ? ad_out : rd_drive;
  ebcr_core i_dut (.I_CLK(clk), .I_NRST(nrst), .I_CE(ce), .I_LINK_CLK(link_clk), .I_REQ_VALID(req_valid),
    .I_REQ(req), .I_CFG(cfg), .O_REQ_READY(req_ready), .O_DONE(done), .O_RDATA(rdata),
    .O_REF_CLK_FAST(ref_fast), .I_READY(ready), .I_AD(ad_in), .I_D(rd_drive), .O_CS_N(cs_n), .O_ALE(ale),
    .O_RD_N(rd_n), .O_WRL_N(wrl_n), .O_WRH_N(wrh_n), .O_BHE_N(bhe_n), .O_ADDR(addr), .O_AD(ad_out),
    .O_AD_OE(ad_oe), .O_D(d_out), .O_D_OE(d_oe));
  ebcr_mem_model i_mem (.clk(link_clk), .nrst(nrst), .ready_high(cfg.ready_active_high),
    .shared(cfg.shared_bus_mode), .wait_cyc(wait_cyc), .cs_n(cs_n), .ale(ale), .rd_n(rd_n),
    .wrl_n(wrl_n), .wrh_n(wrh_n), .addr(addr), .ad_out(ad_out), .ad_oe(ad_oe), .d_out(d_out),
    .ready(ready), .rd_drive(rd_drive));
  initial forever #4 clk = !clk;
  initial begin
    #13;
    forever #40 link_clk = !link_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Pin monitor, sampled mid bus clock where registered pins are settled
  always @(negedge link_clk) begin
    if (cs_n === 1'b0) cs_cnt++;
    if (ale === 1'b1) ale_cnt++;
    if (rd_n === 1'b0 || wrl_n === 1'b0 || wrh_n === 1'b0) str_cnt++;
    if ((wrh_n === 1'b0 && !be_cur[1]) || (wrl_n === 1'b0 && !be_cur[0])) lane_bad++;
    if (cs_n === 1'b0 && bhe_n !== !be_cur[1]) lane_bad++;
    if (cs_n === 1'b0 && addr !== req.addr) lane_bad++;
    // A read with any line driven would fight the peripheral
    if (rd_n === 1'b0 && (ad_oe !== 1'b0 || d_oe !== 1'b0)) lane_bad++;
    if ((wrl_n === 1'b0 || wrh_n === 1'b0) && (d_oe !== !cfg.shared_bus_mode || ad_oe !== cfg.shared_bus_mode)) lane_bad++;
  end
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("Error %0t: %s", $time, msg);
    end
  endtask
  task end_sim;
    if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  function automatic int ab_of(input logic [2:0] code);
    return code == 3'h5 ? 5 : (code == 3'h2 ? 2 : 1);
  endfunction
  // One whole bus cycle, then the pin counts are judged against the phase settings
  task automatic xfer(input logic wr, input logic [1:0] be, input logic [23:0] a, input logic [15:0] wd);
    int n, ab, e, sum;
    ab = ab_of(cfg.address_phase_length);
    e = int'(cfg.access_phase_length) + 1;
    sum = ab + int'(cfg.delay_phase_length) + e + int'(cfg.hold_phase_length);
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    cs_cnt = 0;
    ale_cnt = 0;
    str_cnt = 0;
    lane_bad = 0;
    be_cur = be;
    req = '{write: wr, byte_en: be, addr: a, wdata: wd};
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 8000) begin
      @(negedge clk);
      n++;
    end
    chk(done === 1'b1, "cycle never completed");
    if (!cfg.ready_en) begin
      chk(str_cnt == e, "strobe length differs from access phase");
      if (wr) chk(cs_cnt == sum + int'(cfg.write_data_setup_phase_length), "write cycle length");
    end else begin
      chk(str_cnt >= e && str_cnt > int'(wait_cyc), "ready did not stretch access");
      chk(str_cnt <= e + int'(wait_cyc) + 4, "ready seen active but cycle kept on");
      if (cfg.ready_async) chk(str_cnt >= e + 1, "async ready without wait state");
    end
    if (!wr) chk(cs_cnt >= sum && cs_cnt <= sum + 1 + str_cnt - e, "read cycle length");
    chk(ale_cnt == (cfg.shared_bus_mode ? ab : 0), "latch strobe length");
    chk(lane_bad == 0, "byte lane strobes");
    if (!wr) chk(rdata === shadow[a[7:0]], "read data");
    if (wr && be[0]) shadow[a[7:0]][7:0] = wd[7:0];
    if (wr && be[1]) shadow[a[7:0]][15:8] = wd[15:8];
  endtask
  task automatic new_cfg(input int i);
    logic [31:0] r;
    r = $urandom;
    cfg = r[16:0];
    cfg.access_phase_length = 5'($urandom_range(0, 3));
    wait_cyc = 4'($urandom_range(0, 5));
    if (i == 0) begin
      cfg.address_phase_length = 3'h5;
      cfg.access_phase_length = 5'h1f;
      cfg.ready_en = 1'b0;
    end
    if (i == 1) begin
      cfg.ready_en = 1'b1;
      cfg.ready_async = 1'b1;
      wait_cyc = 4'h0;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [23:0] a;
    void'($urandom(48));
    repeat (6) @(negedge clk);
    // No reset edge at time zero, so link flops only settle on their own clock edges
    repeat (2) @(posedge link_clk);
    @(negedge clk);
    chk(cs_n === 1'b1 && rd_n === 1'b1 && ale === 1'b0 && req_ready === 1'b0 && done === 1'b0, "reset values");
    nrst = 1'b1;
    repeat (3) @(posedge link_clk);
    @(negedge clk);
    chk(ref_fast === 1'b1, "reference clock driver");
    for (int i = 0; i < 24; i++) begin
      if (i == 3) begin
        // Freeze both domains between cycles; the following transfers must run cleanly
        @(negedge clk);
        ce = 1'b0;
        repeat (20) @(negedge clk);
        chk(req_ready === 1'b1 && cs_n === 1'b1 && done === 1'b0, "state kept while clock enable low");
        ce = 1'b1;
      end
      a = 24'($urandom);
      new_cfg(i);
      xfer(1'b1, 2'b11, a, 16'($urandom));
      new_cfg(i + 2);
      xfer(1'b1, 2'($urandom_range(1, 3)), a, 16'($urandom));
      new_cfg(i + 2);
      xfer(1'b0, 2'($urandom_range(1, 3)), a, 16'h0000);
    end
    end_sim;
  end
  initial begin
    // 72 transfers, the longest about 50 bus clocks and the rest under about 30, well inside the limit
    #400000;
    bad_count++;
    $display("Error %0t: timeout", $time);
    end_sim;
  end
endmodule
